// ===== rtl/gpe_edge_det.v
`timescale 1ns/1ps
`include "gpe_map.vh"

module gpe_edge_det #(
  parameter W = 8
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Raw inputs
  input wire [W-1:0] sig_in,
  // One-cycle edge pulses
  output reg [W-1:0] rise_reg,
  output reg [W-1:0] fall_reg
);

  reg [W-1:0] sync1_reg;
  reg [W-1:0] sync2_reg;
  reg [W-1:0] last_reg;
  reg [1:0] fill_reg;

  // Two-flop synchroniser, then compare successive samples
  // Edges are ignored until the pipeline holds real pin samples, so a pin
  // that idles high does not report a false edge after reset
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg <= {W{1'b0}};
      sync2_reg <= {W{1'b0}};
      last_reg <= {W{1'b0}};
      rise_reg <= {W{1'b0}};
      fall_reg <= {W{1'b0}};
      fill_reg <= 2'h0;
    end
    else
    begin
      sync1_reg <= sig_in;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
      if (fill_reg != `GPE_SYNC_FILL)
        fill_reg <= fill_reg + 2'h1;
      if (fill_reg == `GPE_SYNC_FILL)
      begin
        rise_reg <= sync2_reg & ~last_reg;
        fall_reg <= ~sync2_reg & last_reg;
      end
      else
      begin
        rise_reg <= {W{1'b0}};
        fall_reg <= {W{1'b0}};
      end
    end
  end

endmodule

// ===== rtl/gpe_map.vh
`ifndef GPE_MAP_VH
`define GPE_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define GPE_OFF_OUT_LO 8'h04
`define GPE_OFF_EN_LO 8'h08
`define GPE_OFF_FS_LO 8'h0C
`define GPE_OFF_OUT_HI 8'hB4
`define GPE_OFF_EN_HI 8'hB8
`define GPE_OFF_FS_HI 8'hBC
`define GPE_OFF_STAT 8'hC0
`define GPE_OFF_IEN 8'hC4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GPE_RST_REG 32'h00000000

// ----------------------------------------------------------------------
// Status field layout
// ----------------------------------------------------------------------
`define GPE_STAT_MASK 32'h007F7F7F
`define GPE_RISE_LSB 0
`define GPE_FALL_LSB 8
`define GPE_DEC_LSB 16
`define GPE_ENC_LSB 20
`define GPE_NUM_STAT_EDGE 7
`define GPE_PIN_AUDIO_CLK3 35

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define GPE_SYNC_FILL 2'h3

// ----------------------------------------------------------------------
// Bus response codes
// ----------------------------------------------------------------------
`define GPE_RESP_OKAY 2'h0
`define GPE_RESP_SLVERR 2'h2

`endif

// ===== rtl/gpe_pin_mux.v
`timescale 1ns/1ps

module gpe_pin_mux #(
  parameter W = 64
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Software control per pin
  input wire [W-1:0] fsel,
  input wire [W-1:0] oe,
  input wire [W-1:0] val,
  // Primary function per pin
  input wire [W-1:0] prim_out,
  input wire [W-1:0] prim_oe,
  // Pad side
  output reg [W-1:0] pad_out_reg,
  output reg [W-1:0] pad_oe_n_reg
);

  // Select primary logic or general output mode per pin
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad_out_reg <= {W{1'b0}};
      pad_oe_n_reg <= {W{1'b1}};
    end
    else
    begin
      pad_out_reg <= (fsel & val) | (~fsel & prim_out);
      pad_oe_n_reg <= (fsel & ~oe) | (~fsel & ~prim_oe);
    end
  end

endmodule

// ===== rtl/gpe_top.v
`timescale 1ns/1ps
`include "gpe_map.vh"

module gpe_top #(
  parameter ADDR_W = 8,
  parameter NPIN = 64,
  parameter NEDGE = 8
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Primary function drive per pin
  input wire [NPIN-1:0] prim_out,
  input wire [NPIN-1:0] prim_oe,
  // Pads
  output wire [NPIN-1:0] pin_out,
  output wire [NPIN-1:0] pin_oe_n,
  // Edge-capable inputs and audio events
  input wire [NEDGE-1:0] edge_in,
  input wire [3:0] dec_event,
  input wire [2:0] enc_event,
  // Secondary controller lines and summary interrupt
  output reg [NEDGE-1:0] sic_edge_line,
  output reg [3:0] sic_audio_line,
  output reg irq
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  reg [31:0] out_lo_reg;
  reg [31:0] en_lo_reg;
  reg [31:0] fs_lo_reg;
  reg [31:0] out_hi_reg;
  reg [31:0] en_hi_reg;
  reg [31:0] fs_hi_reg;
  reg [31:0] stat_reg;
  reg [31:0] ien_reg;
  reg [31:0] stat_next;
  reg [31:0] rd_data_next;
  reg rd_hit_next;

  wire [NEDGE-1:0] rise;
  wire [NEDGE-1:0] fall;
  wire [31:0] stat_set;
  wire [31:0] stat_clr;
  wire [31:0] stat_act;
  wire wr_fire;
  wire rd_fire;
  wire [31:0] wmask;
  wire wr_start;
  wire rd_start;
  wire [NEDGE-1:0] edge_line_next;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // True when an address selects one of the words of the map
  function addr_hit;
    input [ADDR_W-1:0] a;
    begin
      addr_hit = (a == `GPE_OFF_OUT_LO) || (a == `GPE_OFF_EN_LO) ||
        (a == `GPE_OFF_FS_LO) || (a == `GPE_OFF_OUT_HI) ||
        (a == `GPE_OFF_EN_HI) || (a == `GPE_OFF_FS_HI) ||
        (a == `GPE_OFF_STAT) || (a == `GPE_OFF_IEN);
    end
  endfunction

  // Expand byte strobes to a bit mask
  function [31:0] strb_mask;
    input [3:0] s;
    begin
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  assign wr_fire = s_axi_awvalid & s_axi_awready;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign wmask = strb_mask(s_axi_wstrb);

  // Accept only with both halves present and no answer outstanding
  assign wr_start = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  assign rd_start = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;

  // Write channel: take address and data together, then respond
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GPE_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= wr_start;
      s_axi_wready <= wr_start;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_hit(s_axi_awaddr) ? `GPE_RESP_OKAY : `GPE_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode
  always @*
  begin
    rd_data_next = 32'h00000000;
    rd_hit_next = 1'b1;
    if (s_axi_araddr == `GPE_OFF_OUT_LO)
      rd_data_next = out_lo_reg;
    else if (s_axi_araddr == `GPE_OFF_EN_LO)
      rd_data_next = en_lo_reg;
    else if (s_axi_araddr == `GPE_OFF_FS_LO)
      rd_data_next = fs_lo_reg;
    else if (s_axi_araddr == `GPE_OFF_OUT_HI)
      rd_data_next = out_hi_reg;
    else if (s_axi_araddr == `GPE_OFF_EN_HI)
      rd_data_next = en_hi_reg;
    else if (s_axi_araddr == `GPE_OFF_FS_HI)
      rd_data_next = fs_hi_reg;
    else if (s_axi_araddr == `GPE_OFF_STAT)
      rd_data_next = stat_reg;
    else if (s_axi_araddr == `GPE_OFF_IEN)
      rd_data_next = ien_reg;
    else
      rd_hit_next = addr_hit(s_axi_araddr);
  end

  // Read channel: one cycle to accept, data the next
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `GPE_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= rd_start;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data_next;
        s_axi_rresp <= rd_hit_next ? `GPE_RESP_OKAY : `GPE_RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin control banks
  // ----------------------------------------------------------------------
  // Low bank covers pins 0-31, high bank pins 32-63
  // Writes to an unmapped word change nothing
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_lo_reg <= `GPE_RST_REG;
      en_lo_reg <= `GPE_RST_REG;
      fs_lo_reg <= `GPE_RST_REG;
      out_hi_reg <= `GPE_RST_REG;
      en_hi_reg <= `GPE_RST_REG;
      fs_hi_reg <= `GPE_RST_REG;
      ien_reg <= `GPE_RST_REG;
    end
    else if (wr_fire)
    begin
      if (s_axi_awaddr == `GPE_OFF_OUT_LO)
        out_lo_reg <= (out_lo_reg & ~wmask) | (s_axi_wdata & wmask);
      else if (s_axi_awaddr == `GPE_OFF_EN_LO)
        en_lo_reg <= (en_lo_reg & ~wmask) | (s_axi_wdata & wmask);
      else if (s_axi_awaddr == `GPE_OFF_FS_LO)
        fs_lo_reg <= (fs_lo_reg & ~wmask) | (s_axi_wdata & wmask);
      else if (s_axi_awaddr == `GPE_OFF_OUT_HI)
        out_hi_reg <= (out_hi_reg & ~wmask) | (s_axi_wdata & wmask);
      else if (s_axi_awaddr == `GPE_OFF_EN_HI)
        en_hi_reg <= (en_hi_reg & ~wmask) | (s_axi_wdata & wmask);
      else if (s_axi_awaddr == `GPE_OFF_FS_HI)
        fs_hi_reg <= (fs_hi_reg & ~wmask) | (s_axi_wdata & wmask);
      else if (s_axi_awaddr == `GPE_OFF_IEN)
        ien_reg <= (ien_reg & ~wmask) | (s_axi_wdata & wmask);
    end
  end

  // Per-pin mux between primary logic and general output mode
  gpe_pin_mux #(
    .W(NPIN)
  ) u_pin_mux (
    .aclk(aclk),
    .aresetn(aresetn),
    .fsel({fs_hi_reg, fs_lo_reg}),
    .oe({en_hi_reg, en_lo_reg}),
    .val({out_hi_reg, out_lo_reg}),
    .prim_out(prim_out),
    .prim_oe(prim_oe),
    .pad_out_reg(pin_out),
    .pad_oe_n_reg(pin_oe_n)
  );

  // ----------------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------------
  // Edges are captured whatever the select bit; software picks the mode
  gpe_edge_det #(
    .W(NEDGE)
  ) u_edge_det (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_in(edge_in),
    .rise_reg(rise),
    .fall_reg(fall)
  );

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  // Event bits; input 7 has no status bit
  assign stat_set = {9'h000, enc_event, dec_event, 1'b0,
    fall[`GPE_NUM_STAT_EDGE-1:0], 1'b0, rise[`GPE_NUM_STAT_EDGE-1:0]};
  // Clear strobes follow the byte enables, as for any other write
  assign stat_clr = (wr_fire && s_axi_awaddr == `GPE_OFF_STAT) ?
    (s_axi_wdata & wmask) : 32'h00000000;
  assign stat_act = stat_reg & ien_reg;

  // Set wins over a clear in the same cycle
  always @*
  begin
    stat_next = ((stat_reg & ~stat_clr) | stat_set) & `GPE_STAT_MASK;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      stat_reg <= `GPE_RST_REG;
    else
      stat_reg <= stat_next;
  end

  // ----------------------------------------------------------------------
  // Secondary controller lines
  // ----------------------------------------------------------------------
  // Both edges of input n share line 32+n
  genvar gi;
  generate
    for (gi = 0; gi < `GPE_NUM_STAT_EDGE; gi = gi + 1)
    begin : g_edge_line
      assign edge_line_next[gi] = stat_act[`GPE_RISE_LSB + gi] |
        stat_act[`GPE_FALL_LSB + gi];
    end
  endgenerate

  // Input 7 has no status bit: one pulse per edge on line 39
  assign edge_line_next[NEDGE-1] = rise[NEDGE-1] | fall[NEDGE-1];

  // One process drives every edge line, so each bit has a single driver
  always @(posedge aclk)
  begin
    if (!aresetn)
      sic_edge_line <= {NEDGE{1'b0}};
    else
      sic_edge_line <= edge_line_next;
  end

  // Audio lines 53..56 in bits 0..3; decoder and encoder share lines
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sic_audio_line <= 4'h0;
    end
    else
    begin
      sic_audio_line[3] <= stat_act[`GPE_DEC_LSB] | stat_act[`GPE_ENC_LSB];
      sic_audio_line[2] <= stat_act[`GPE_DEC_LSB + 1] | stat_act[`GPE_ENC_LSB + 1];
      sic_audio_line[1] <= stat_act[`GPE_DEC_LSB + 2] | stat_act[`GPE_ENC_LSB + 2];
      sic_audio_line[0] <= stat_act[`GPE_DEC_LSB + 3];
    end
  end

  // Summary interrupt: level while any unmasked status bit is set
  always @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |stat_act;
  end

endmodule

// ===== tb/gpe_pad_model.sv
`timescale 1ns/1ps

// Pads outside the block, with a pull-up on every pin
module gpe_pad_model (
  // Pad drive from the block
  input wire [63:0] pin_out,
  input wire [63:0] pin_oe_n,
  // Level seen on each pad
  output wire [63:0] pad_lvl
);
  // A released pad floats up to the pull-up level
  assign pad_lvl = pin_out | pin_oe_n;
endmodule

// ===== tb/gpe_props.sv
`timescale 1ns/1ps

module gpe_props #(
  parameter NPIN = 64,
  parameter NEDGE = 8
) (
  // Clock, reset and write handshake
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_wvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  // Pins, events and interrupt lines
  input wire [NPIN-1:0] prim_out,
  input wire [NPIN-1:0] prim_oe,
  input wire [NPIN-1:0] pin_out,
  input wire [NPIN-1:0] pin_oe_n,
  input wire [NEDGE-1:0] edge_in,
  input wire [3:0] dec_event,
  input wire [NEDGE-1:0] sic_edge_line,
  input wire [3:0] sic_audio_line,
  input wire irq
);
  reg [1:0] up_reg;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since reset release, saturating
  always @(posedge aclk)
    if (!aresetn) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  sequence s_wr;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence s_resp;
    s_axi_bvalid ##1 !s_axi_bvalid;
  endsequence
  property p_wr_resp;
    s_wr |=> s_resp;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_busy;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_busy: assert property (p_busy) else $error("write taken while busy");
  property p_prim;
    up_reg == 2'h2 |-> pin_out == $past(prim_out) && pin_oe_n == ~$past(prim_oe);
  endproperty
  a_prim: assert property (p_prim) else $error("pins not primary");
  property p_irq_sum;
    irq == ((|sic_edge_line[6:0]) || (|sic_audio_line));
  endproperty
  a_irq_sum: assert property (p_irq_sum) else $error("irq mismatch");
  property p_irq_fall;
    $fell(irq) |-> $past(s_axi_awready, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  property p_audio;
    $rose(sic_audio_line[0]) |-> $past(dec_event[3], 2) || $past(s_axi_awready, 2);
  endproperty
  a_audio: assert property (p_audio) else $error("line 53 no cause");
  property p_line7;
    sic_edge_line[7] == ($past(edge_in[7], 4) != $past(edge_in[7], 5));
  endproperty
  a_line7: assert property (p_line7) else $error("line 39 pulse wrong");
  property p_line0;
    $rose(sic_edge_line[0]) |->
      $past(edge_in[0], 5) != $past(edge_in[0], 6) || $past(s_axi_awready, 2);
  endproperty
  a_line0: assert property (p_line0) else $error("line 32 no cause");
endmodule

bind gpe_top gpe_props #(.NPIN(NPIN), .NEDGE(NEDGE)) gpe_props_inst (.*);

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "gpe_map.vh"

module testbench;
  localparam logic [1:0] OK = `GPE_RESP_OKAY;
  localparam logic [1:0] ERR = `GPE_RESP_SLVERR;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [63:0] prim_out = 64'h3C3C96960F0FA5A5, prim_oe = 64'h6666F00FCCCC0FF0;
  logic [7:0] edge_in = 0;
  logic [3:0] dec_event = 0;
  logic [2:0] enc_event = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [63:0] pin_out, pin_oe_n, pad_lvl;
  wire [7:0] sic_edge_line;
  wire [3:0] sic_audio_line;
  integer num_errors = 0, checked = 0, i;
  logic [7:0] regs [0:7] = '{`GPE_OFF_OUT_LO, `GPE_OFF_EN_LO, `GPE_OFF_FS_LO,
    `GPE_OFF_OUT_HI, `GPE_OFF_EN_HI, `GPE_OFF_FS_HI, `GPE_OFF_STAT, `GPE_OFF_IEN};
  logic [31:0] pat [0:5] = '{32'hA5A55A5A, 32'hFF00FF00, 32'hF0F0F0F0,
    32'h12345678, 32'h0000FFFF, 32'h0F0F0F0F};

  gpe_top gpe_top_inst (.*);
  gpe_pad_model gpe_pad_model_inst (.*);

  // Clock at 100 ns period
  initial forever #50 aclk = ~aclk;

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  task summarize;
    begin
      if (num_errors == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // One bus access; for a read d is the expected data
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    integer n;
    logic done;
    begin
      done = 0;
      @(posedge aclk);
      if (w)
      begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
      end
      else
      begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
      end
      for (n = 0; n < 40 && !done; n = n + 1)
      begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (w && s_axi_bvalid)
        begin
          done = 1;
          s_axi_bready <= 1'b0;
          chk(s_axi_bresp, er);
        end
        if (!w && s_axi_rvalid)
        begin
          done = 1;
          s_axi_rready <= 1'b0;
          chk(s_axi_rdata, d);
          chk(s_axi_rresp, er);
        end
      end
      if (!done)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t: bus access timed out", $time);
        summarize;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1) acc(0, regs[i], 0, OK);
    chk(pin_out, prim_out);
    chk(pin_oe_n, ~prim_oe);
    for (i = 0; i < 6; i = i + 1) acc(1, regs[i], pat[i], OK);
    for (i = 0; i < 6; i = i + 1) acc(0, regs[i], pat[i], OK);
    chk(pin_out, {pat[5] & pat[3], pat[2] & pat[0]} | ~{pat[5], pat[2]} & prim_out);
    chk(~pin_oe_n, {pat[5] & pat[4], pat[2] & pat[1]} | ~{pat[5], pat[2]} & prim_oe);
    // Pin 35 through every enable and value pair
    for (i = 0; i < 4; i = i + 1)
    begin
      acc(1, `GPE_OFF_OUT_HI, {28'h0, i[0], 3'h0}, OK);
      acc(1, `GPE_OFF_EN_HI, {28'h0, i[1], 3'h0}, OK);
      repeat (2) @(posedge aclk);
      chk(pin_oe_n[35], !i[1]);
      chk(pad_lvl[35], i[1] ? i[0] : 1'b1);
    end
    // Byte strobes: only byte 1 of the low value word may change
    s_axi_wstrb <= 4'h2;
    acc(1, `GPE_OFF_OUT_LO, 32'hFFFFFFFF, OK);
    s_axi_wstrb <= 4'hF;
    acc(0, `GPE_OFF_OUT_LO, (pat[0] & 32'hFFFF00FF) | 32'h0000FF00, OK);
    acc(1, 8'h10, 32'hFFFFFFFF, ERR);
    acc(0, 8'h10, 0, ERR);
    // Rising edges, then clear one bit at a time
    acc(1, `GPE_OFF_FS_LO, 32'hF0F0F000, OK);
    acc(1, `GPE_OFF_IEN, `GPE_STAT_MASK, OK);
    edge_in <= 8'h7F;
    repeat (6) @(posedge aclk);
    chk({irq, sic_edge_line}, 9'h17F);
    acc(0, `GPE_OFF_STAT, 32'h0000007F, OK);
    for (i = 0; i < 7; i = i + 1)
    begin
      acc(1, `GPE_OFF_STAT, 32'h1 << i, OK);
      acc(0, `GPE_OFF_STAT, 32'h7F & ~((32'h2 << i) - 32'h1), OK);
    end
    chk(irq, 0);
    // Falling edges while masked; input 7 has no status bit
    acc(1, `GPE_OFF_IEN, 32'h0, OK);
    edge_in <= 8'h80;
    repeat (8) @(posedge aclk);
    chk(irq, 0);
    acc(0, `GPE_OFF_STAT, 32'h00007F00, OK);
    acc(1, `GPE_OFF_IEN, `GPE_STAT_MASK, OK);
    repeat (2) @(posedge aclk);
    chk(irq, 1);
    acc(1, `GPE_OFF_STAT, 32'h00007F00, OK);
    acc(0, `GPE_OFF_STAT, 0, OK);
    // Each audio event in turn
    for (i = 0; i < 7; i = i + 1)
    begin
      {enc_event, dec_event} <= 7'h1 << i;
      @(posedge aclk);
      {enc_event, dec_event} <= 7'h0;
      repeat (3) @(posedge aclk);
      chk(sic_audio_line, 4'h8 >> (i % 4));
      acc(0, `GPE_OFF_STAT, 32'h10000 << i, OK);
      acc(1, `GPE_OFF_STAT, 32'h10000 << i, OK);
    end
    // Reset in mid-run with the inputs high: no false edge, pins primary again
    aresetn <= 1'b0;
    edge_in <= 8'hFF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    acc(0, `GPE_OFF_STAT, 0, OK);
    acc(0, `GPE_OFF_FS_LO, 0, OK);
    acc(0, `GPE_OFF_FS_HI, 0, OK);
    chk(pin_out, prim_out);
    chk(pin_oe_n, ~prim_oe);
    summarize;
  end
endmodule
